// ===== core/lbad_region_dec.v
// address region classifier for the local bus
`timescale 1ns/1ns
`default_nettype none
`include "lbad_regs.vh"
module lbad_region_dec (
	// access
	input  wire [31:0] addr_i,
	input  wire        mirror_i,
	input  wire        vme_present_i,
	// result
	output reg  [2:0]  region_o
);
	function in_rng;
		input [31:0] a;
		input [31:0] lo;
		input [31:0] hi;
		begin
			in_rng = (a >= lo) && (a <= hi);
		end
	endfunction

	wire [31:0] wa = {addr_i[31:2], 2'b00};
	wire        own;
	assign own = (wa == `LBAD_A_GPIN) || (wa == `LBAD_A_ABORT) ||
		(wa == `LBAD_A_WDOG) || (wa == `LBAD_A_BERR) ||
		(wa == `LBAD_A_PRESC) || (wa == `LBAD_A_BCTL) ||
		(!vme_present_i && ((wa == `LBAD_A_PRESC2) ||
		(wa == `LBAD_A_ROMCTL)));

	// one code only per address
	always @* begin
		if (mirror_i && addr_i <= `LBAD_MIRROR_TOP) begin
			region_o = `LBAD_RG_ROM;
		end else if (addr_i < `LBAD_ROM_LO) begin
			region_o = `LBAD_RG_MEM;
		end else if (in_rng(addr_i, `LBAD_ROM_LO, `LBAD_ROM_HI)) begin
			region_o = `LBAD_RG_ROM;
		end else if (in_rng(addr_i, `LBAD_SRAM_LO, `LBAD_SRAM_HI)) begin
			region_o = `LBAD_RG_SRAM;
		end else if (own) begin
			region_o = `LBAD_RG_OWN;
		end else if (in_rng(addr_i, `LBAD_LIO_LO, `LBAD_LIO_HI)) begin
			region_o = `LBAD_RG_LIO;
		end else if (addr_i >= `LBAD_A16_LO) begin
			region_o = `LBAD_RG_A16;
		end else begin
			region_o = `LBAD_RG_NONE;
		end
	end
endmodule // lbad_region_dec
`default_nettype wire

// ===== core/lbad_regs.vh
// register map, field positions, reset values and timing counts
`ifndef LBAD_REGS_VH
`define LBAD_REGS_VH

// region codes
`define LBAD_RG_NONE    3'h0
`define LBAD_RG_MEM     3'h1
`define LBAD_RG_ROM     3'h2
`define LBAD_RG_SRAM    3'h3
`define LBAD_RG_LIO     3'h4
`define LBAD_RG_A16     3'h5
`define LBAD_RG_OWN     3'h6

// transfer type codes
`define LBAD_TT_IACK    2'h3

// address map
`define LBAD_MIRROR_TOP 32'h003F_FFFF
`define LBAD_ROM_LO     32'hFF80_0000
`define LBAD_ROM_HI     32'hFFBF_FFFF
`define LBAD_SRAM_LO    32'hFFE0_0000
`define LBAD_SRAM_HI    32'hFFEF_FFFF
`define LBAD_LIO_LO     32'hFFF0_0000
`define LBAD_LIO_HI     32'hFFFE_FFFF
`define LBAD_A16_LO     32'hFFFF_0000

// own registers (word addresses)
`define LBAD_A_GPIN     32'hFFF4_202C
`define LBAD_A_ABORT    32'hFFF4_2040
`define LBAD_A_WDOG     32'hFFF4_2044
`define LBAD_A_BERR     32'hFFF4_2048
`define LBAD_A_PRESC    32'hFFF4_204C
`define LBAD_A_BCTL     32'hFFF4_2050
`define LBAD_A_PRESC2   32'hFFF4_0064
`define LBAD_A_ROMCTL   32'hFFF4_0030

// field positions
`define LBAD_GPIN_LSB   16
`define LBAD_AB_LVL_MSB 2
`define LBAD_AB_CLR     3
`define LBAD_AB_EN      4
`define LBAD_AB_PEND    5
`define LBAD_AB_SW      6
`define LBAD_WD_WSEL    8
`define LBAD_WD_TSEL    12
`define LBAD_WD_EN      16
`define LBAD_WD_RSTEN   17
`define LBAD_WD_KICK    19
`define LBAD_WD_STAT    20
`define LBAD_WD_STCLR   21
`define LBAD_WD_FAILEN  22
`define LBAD_RS_EN      24
`define LBAD_RS_STAT    28
`define LBAD_BE_LSB     8
`define LBAD_MIRROR_BIT 20

// reset values and abort vector
`define LBAD_RST_BCTL   3'h1
`define LBAD_RST_TSEL   2'h3
`define LBAD_RST_WSEL   4'h0
`define LBAD_RST_LVL    3'h0
`define LBAD_ABORT_VEC  8'h40

// timing
`define LBAD_CLK_NS     10
`define LBAD_US_NS      1000
`define LBAD_US_CYC     (`LBAD_US_NS / `LBAD_CLK_NS)
`define LBAD_TO1_US     8
`define LBAD_TO1_CYC    (`LBAD_TO1_US * `LBAD_US_CYC)
`define LBAD_TO2_US     64
`define LBAD_TO3_US     256
`define LBAD_WD_BASE_US 512

`endif

// ===== core/lbad_timer.v
// microsecond prescaler and watchdog counter
`timescale 1ns/1ns
`default_nettype none
`include "lbad_regs.vh"
module lbad_timer #(
	parameter [31:0] WD_BASE_US = `LBAD_WD_BASE_US
) (
	// clock and reset
	input  wire        clk_sys_i,
	input  wire        resetn_i,
	// prescaler write
	input  wire        pre_we_i,
	input  wire [31:0] pre_wdata_i,
	input  wire [31:0] pre_wmask_i,
	// watchdog control
	input  wire        wd_en_i,
	input  wire        wd_kick_i,
	input  wire [3:0]  wd_sel_i,
	// status
	output reg  [31:0] presc_o,
	output reg         wd_expire_o
);
	localparam [31:0] US_CYC  = `LBAD_US_CYC;
	localparam [6:0]  US_LAST = US_CYC[6:0] - 7'h01;
	reg  [6:0]  div_r;
	reg  [31:0] wd_cnt_r;
	wire        tick = (div_r == US_LAST);
	wire [31:0] wd_lim = WD_BASE_US << wd_sel_i;

	always @(posedge clk_sys_i) begin
		if (!resetn_i) begin
			div_r       <= 7'h00;
			presc_o     <= 32'h0000_0000;
			wd_cnt_r    <= 32'h0000_0000;
			wd_expire_o <= 1'b0;
		end else begin
			div_r       <= tick ? 7'h00 : div_r + 7'h01;
			wd_expire_o <= 1'b0;
			if (pre_we_i) begin
				presc_o <= (presc_o & ~pre_wmask_i) |
					(pre_wdata_i & pre_wmask_i);
			end else if (tick) begin
				presc_o <= presc_o + 32'h0000_0001;
			end
			if (!wd_en_i || wd_kick_i) begin
				wd_cnt_r <= 32'h0000_0000;
			end else if (tick) begin
				if (wd_cnt_r + 32'h0000_0001 >= wd_lim) begin
					wd_cnt_r    <= 32'h0000_0000;
					wd_expire_o <= 1'b1;
				end else begin
					wd_cnt_r <= wd_cnt_r + 32'h0000_0001;
				end
			end
		end
	end
endmodule // lbad_timer
`default_nettype wire

// ===== core/lbad_top.v
// local bus address decode and redundant board control
`timescale 1ns/1ns
`default_nettype none
`include "lbad_regs.vh"
module lbad_top #(
	parameter [31:0] TO2_CYC    = `LBAD_TO2_US * `LBAD_US_CYC,
	parameter [31:0] TO3_CYC    = `LBAD_TO3_US * `LBAD_US_CYC,
	parameter [31:0] WD_BASE_US = `LBAD_WD_BASE_US
) (
	// clock and reset
	input  wire        clk_sys_i,
	input  wire        resetn_i,
	// local bus request
	input  wire        ts_i,
	input  wire [1:0]  transfer_type_code_i,
	input  wire [31:0] addr_i,
	input  wire        rd_i,
	input  wire [3:0]  be_i,
	input  wire [31:0] wdata_i,
	// external target answers
	input  wire        ext_ack_i,
	input  wire        ext_err_i,
	// local bus answer
	output reg         ta_o,
	output reg         transfer_error_ack_o,
	output reg  [31:0] rdata_o,
	// region selects
	output reg         sel_mem_o,
	output reg         sel_rom_o,
	output reg         sel_sram_o,
	output reg         sel_lio_o,
	output reg         sel_a16_o,
	// board inputs
	input  wire        vme_present_i,
	input  wire        supply_status_line_i,
	input  wire [7:0]  general_input_pins_i,
	input  wire        abort_sw_i,
	input  wire        reset_sw_i,
	// board control outputs
	output reg         flash_protect_line_o,
	output reg         flash_half_select_line_o,
	output reg         boot_config_select_line_o,
	output reg         boot_mirror_bit_o,
	output reg         abort_irq_o,
	output reg  [2:0]  abort_level_o,
	output reg         local_reset_o,
	output reg         board_fail_o
);
	localparam [1:0] ST_IDLE = 2'd0;
	localparam [1:0] ST_WAIT = 2'd1;
	localparam [31:0] TO1_CYC = `LBAD_TO1_CYC;

	function [31:0] lane_mask;
		input [3:0] be;
		begin
			lane_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
		end
	endfunction

	function [31:0] to_limit;
		input [1:0] sel;
		begin
			case (sel)
				2'd0:    to_limit = TO1_CYC;
				2'd1:    to_limit = TO2_CYC;
				default: to_limit = TO3_CYC;
			endcase
		end
	endfunction

	reg  [1:0]  state_r;
	reg  [31:0] to_cnt_r;
	reg         to_arm_r;
	reg         iack_r;
	reg  [3:1]  bctl_r;
	reg  [2:0]  ab_lvl_r;
	reg         ab_en_r;
	reg         ab_pend_r;
	reg         ab_sw_r;
	reg  [1:0]  tsel_r;
	reg  [3:0]  wsel_r;
	reg         wd_en_r;
	reg         wd_rsten_r;
	reg         wd_failen_r;
	reg         wd_stat_r;
	reg         rs_en_r;
	reg  [3:0]  berr_r;
	reg         berr_set_any;
	reg         berr_set_to;
	reg         berr_set_ext;
	reg         berr_set_iack;
	wire [2:0]  region;
	wire [31:0] presc;
	wire        wd_expire;
	wire [31:0] wa = {addr_i[31:2], 2'b00};
	wire [31:0] wm = lane_mask(be_i);
	wire        inhibit = vme_present_i;
	wire        normal = (transfer_type_code_i != `LBAD_TT_IACK);
	wire        req = ts_i && (state_r == ST_IDLE);
	wire        own_wr = req && normal && !rd_i &&
		(region == `LBAD_RG_OWN);
	wire        ab_hit = !inhibit && ab_en_r && ab_pend_r &&
		(addr_i[3:1] == ab_lvl_r);
	wire        pre_we = own_wr && !inhibit &&
		((wa == `LBAD_A_PRESC) || (wa == `LBAD_A_PRESC2));
	wire        wd_kick = own_wr && !inhibit && (wa == `LBAD_A_WDOG) &&
		wm[`LBAD_WD_KICK] && wdata_i[`LBAD_WD_KICK];
	wire        ab_rise = abort_sw_i && !ab_sw_r;
	wire        flash_wr_blk = req && normal && !rd_i && bctl_r[1] &&
		(region == `LBAD_RG_ROM);

	lbad_region_dec u_dec (
		.addr_i        (addr_i),
		.mirror_i      (boot_mirror_bit_o),
		.vme_present_i (vme_present_i),
		.region_o      (region)
	);

	lbad_timer #(
		.WD_BASE_US (WD_BASE_US)
	) u_tmr (
		.clk_sys_i   (clk_sys_i),
		.resetn_i    (resetn_i),
		.pre_we_i    (pre_we),
		.pre_wdata_i (wdata_i),
		.pre_wmask_i (wm),
		.wd_en_i     (wd_en_r && !inhibit),
		.wd_kick_i   (wd_kick),
		.wd_sel_i    (wsel_r),
		.presc_o     (presc),
		.wd_expire_o (wd_expire)
	);

	// read data of own registers
	reg [31:0] rd_mux;
	always @* begin
		rd_mux = 32'h0000_0000;
		if (wa == `LBAD_A_GPIN) begin
			rd_mux[`LBAD_GPIN_LSB+7:`LBAD_GPIN_LSB] =
				general_input_pins_i;
		end else if (wa == `LBAD_A_ABORT) begin
			rd_mux[6:0] = {abort_sw_i, ab_pend_r, ab_en_r, 1'b0,
				ab_lvl_r};
		end else if (wa == `LBAD_A_WDOG) begin
			rd_mux[`LBAD_RS_STAT] = reset_sw_i;
			rd_mux[`LBAD_RS_EN] = rs_en_r;
			rd_mux[`LBAD_WD_FAILEN] = wd_failen_r;
			rd_mux[`LBAD_WD_STAT] = wd_stat_r;
			rd_mux[`LBAD_WD_RSTEN] = wd_rsten_r;
			rd_mux[`LBAD_WD_EN] = wd_en_r;
			rd_mux[13:8] = {tsel_r, wsel_r};
		end else if (wa == `LBAD_A_BERR) begin
			rd_mux[`LBAD_BE_LSB+3:`LBAD_BE_LSB] = berr_r;
		end else if (wa == `LBAD_A_PRESC || wa == `LBAD_A_PRESC2) begin
			rd_mux = presc;
		end else if (wa == `LBAD_A_BCTL) begin
			rd_mux[3:0] = {bctl_r, supply_status_line_i};
		end else if (wa == `LBAD_A_ROMCTL) begin
			rd_mux[`LBAD_MIRROR_BIT] = boot_mirror_bit_o;
		end
	end

	// bus error status sources
	always @* begin
		berr_set_any  = 1'b0;
		berr_set_to   = 1'b0;
		berr_set_ext  = 1'b0;
		berr_set_iack = 1'b0;
		if (flash_wr_blk) begin
			berr_set_any = 1'b1;
		end else if (state_r == ST_WAIT) begin
			if (ext_err_i && !iack_r) begin
				berr_set_any = 1'b1;
				berr_set_ext = 1'b1;
			end else if (!ext_ack_i && to_arm_r &&
				to_cnt_r + 32'h0000_0001 >= to_limit(tsel_r)) begin
				berr_set_any  = 1'b1;
				berr_set_to   = 1'b1;
				berr_set_iack = iack_r;
			end
		end
	end

	// bus cycle handling
	always @(posedge clk_sys_i) begin
		if (!resetn_i) begin
			state_r              <= ST_IDLE;
			to_cnt_r             <= 32'h0000_0000;
			to_arm_r             <= 1'b0;
			iack_r               <= 1'b0;
			ta_o                 <= 1'b0;
			transfer_error_ack_o <= 1'b0;
			rdata_o              <= 32'h0000_0000;
			sel_mem_o            <= 1'b0;
			sel_rom_o            <= 1'b0;
			sel_sram_o           <= 1'b0;
			sel_lio_o            <= 1'b0;
			sel_a16_o            <= 1'b0;
		end else begin
			ta_o                 <= 1'b0;
			transfer_error_ack_o <= berr_set_any;
			sel_mem_o            <= 1'b0;
			sel_rom_o            <= 1'b0;
			sel_sram_o           <= 1'b0;
			sel_lio_o            <= 1'b0;
			sel_a16_o            <= 1'b0;
			case (state_r)
				ST_IDLE: begin
					to_cnt_r <= 32'h0000_0000;
					iack_r   <= 1'b0;
					// undecoded space never timed while inhibited
					to_arm_r <= !inhibit && (tsel_r != 2'd3);
					if (req && normal && !flash_wr_blk) begin
						if (region == `LBAD_RG_OWN) begin
							ta_o    <= 1'b1;
							rdata_o <= rd_i ? rd_mux : 32'h0000_0000;
						end else begin
							state_r    <= ST_WAIT;
							sel_mem_o  <= (region == `LBAD_RG_MEM);
							sel_rom_o  <= (region == `LBAD_RG_ROM);
							sel_sram_o <= (region == `LBAD_RG_SRAM);
							sel_lio_o  <= (region == `LBAD_RG_LIO);
							sel_a16_o  <= (region == `LBAD_RG_A16);
							if (region == `LBAD_RG_A16) begin
								to_arm_r <= 1'b0;
							end
						end
					end else if (req && !normal) begin
						if (ab_hit) begin
							ta_o    <= 1'b1;
							rdata_o <= {24'h00_0000, `LBAD_ABORT_VEC};
						end else begin
							state_r <= ST_WAIT;
							iack_r  <= 1'b1;
						end
					end
				end
				ST_WAIT: begin
					to_cnt_r <= to_cnt_r + 32'h0000_0001;
					if (berr_set_any || ext_ack_i) begin
						state_r <= ST_IDLE;
					end
				end
				default: state_r <= ST_IDLE;
			endcase
		end
	end

	// control registers, abort and reset logic
	always @(posedge clk_sys_i) begin
		if (!resetn_i) begin
			bctl_r            <= `LBAD_RST_BCTL;
			boot_mirror_bit_o <= 1'b1;
			ab_lvl_r          <= `LBAD_RST_LVL;
			ab_en_r           <= 1'b0;
			ab_pend_r         <= 1'b0;
			ab_sw_r           <= 1'b0;
			tsel_r            <= `LBAD_RST_TSEL;
			wsel_r            <= `LBAD_RST_WSEL;
			wd_en_r           <= 1'b0;
			wd_rsten_r        <= 1'b0;
			wd_failen_r       <= 1'b0;
			wd_stat_r         <= 1'b0;
			rs_en_r           <= 1'b0;
			berr_r            <= 4'h0;
		end else begin
			ab_sw_r <= abort_sw_i;
			// mirror bit snooped even when the other chip answers
			if (own_wr || (req && normal && !rd_i && inhibit &&
				wa == `LBAD_A_ROMCTL)) begin
				if (wa == `LBAD_A_ROMCTL && wm[`LBAD_MIRROR_BIT]) begin
					boot_mirror_bit_o <= wdata_i[`LBAD_MIRROR_BIT];
				end
			end
			if (own_wr && wa == `LBAD_A_BCTL && be_i[0]) begin
				bctl_r <= wdata_i[3:1];
			end
			if (own_wr && !inhibit && wa == `LBAD_A_ABORT && be_i[0]) begin
				ab_lvl_r <= wdata_i[`LBAD_AB_LVL_MSB:0];
				ab_en_r  <= wdata_i[`LBAD_AB_EN];
			end
			// set beats clear
			if (ab_rise && !inhibit) begin
				ab_pend_r <= 1'b1;
			end else if (own_wr && wa == `LBAD_A_ABORT && be_i[0] &&
				wdata_i[`LBAD_AB_CLR]) begin
				ab_pend_r <= 1'b0;
			end
			if (own_wr && !inhibit && wa == `LBAD_A_WDOG) begin
				if (be_i[3]) begin
					rs_en_r <= wdata_i[`LBAD_RS_EN];
				end
				if (be_i[2]) begin
					wd_failen_r <= wdata_i[`LBAD_WD_FAILEN];
					wd_rsten_r  <= wdata_i[`LBAD_WD_RSTEN];
					wd_en_r     <= wdata_i[`LBAD_WD_EN];
				end
				if (be_i[1]) begin
					tsel_r <= wdata_i[13:12];
					wsel_r <= wdata_i[11:8];
				end
			end
			if (wd_expire) begin
				wd_stat_r <= 1'b1;
			end else if (own_wr && wa == `LBAD_A_WDOG &&
				wm[`LBAD_WD_STCLR] && wdata_i[`LBAD_WD_STCLR]) begin
				wd_stat_r <= 1'b0;
			end
			berr_r <= (berr_r & ~(own_wr && wa == `LBAD_A_BERR && be_i[1] ?
				wdata_i[11:8] : 4'h0)) |
				{berr_set_iack, berr_set_ext, berr_set_to,
				berr_set_any};
		end
	end

	// board control outputs
	always @(posedge clk_sys_i) begin
		if (!resetn_i) begin
			flash_protect_line_o      <= 1'b1;
			flash_half_select_line_o  <= 1'b0;
			boot_config_select_line_o <= 1'b0;
			abort_irq_o               <= 1'b0;
			abort_level_o             <= `LBAD_RST_LVL;
			local_reset_o             <= 1'b0;
			board_fail_o              <= 1'b0;
		end else begin
			flash_protect_line_o      <= bctl_r[1];
			boot_config_select_line_o <= bctl_r[3];
			// half select only means something in shared mode
			flash_half_select_line_o  <= bctl_r[2] && !bctl_r[3];
			abort_irq_o   <= ab_pend_r && ab_en_r && !inhibit;
			abort_level_o <= ab_lvl_r;
			local_reset_o <= !inhibit && ((rs_en_r && reset_sw_i) ||
				(wd_rsten_r && wd_expire));
			board_fail_o  <= !inhibit && wd_failen_r && wd_stat_r;
		end
	end
endmodule // lbad_top
`default_nettype wire

// ===== verif/lbad_target_model.sv
// external target answering region selects after a set delay
`timescale 1ns/1ns
`default_nettype none
module lbad_target_model (
	// clock
	input  wire logic       clk_sys_i,
	// control
	input  wire logic       sel_i,
	input  wire logic [3:0] delay_i,
	input  wire logic       fail_i,
	// answer
	output logic            ack_o,
	output logic            err_o
);
	logic [3:0] cnt;
	logic       busy;
	initial begin
		ack_o = 1'b0;
		err_o = 1'b0;
		busy = 1'b0;
		cnt = 4'h0;
	end
	// answers stay low outside a pending cycle
	always @(posedge clk_sys_i) begin
		ack_o <= 1'b0;
		err_o <= 1'b0;
		if (sel_i) begin // only this block's selects start a cycle
			busy <= 1'b1;
			cnt <= delay_i;
		end else if (busy) begin
			if (cnt == 4'h0) begin
				busy <= 1'b0;
				ack_o <= !fail_i;
				err_o <= fail_i;
			end else
				cnt <= cnt - 4'h1;
		end
	end
endmodule // lbad_target_model
`default_nettype wire

// ===== verif/lbad_top_monitor.sv
// assertion checker for the local bus decode block
`timescale 1ns/1ns
`default_nettype none
`include "lbad_regs.vh"
module lbad_top_monitor (
	// clock and reset
	input wire logic        clk_sys_i,
	input wire logic        resetn_i,
	// request
	input wire logic        ts_i,
	input wire logic [1:0]  transfer_type_code_i,
	input wire logic [31:0] addr_i,
	input wire logic        rd_i,
	input wire logic [7:0]  general_input_pins_i,
	input wire logic        vme_present_i,
	// answer and selects
	input wire logic        ta_o,
	input wire logic [31:0] rdata_o,
	input wire logic        sel_mem_o,
	input wire logic        sel_rom_o,
	input wire logic        sel_sram_o,
	input wire logic        sel_lio_o,
	input wire logic        sel_a16_o,
	// board control
	input wire logic        flash_protect_line_o,
	input wire logic        flash_half_select_line_o,
	input wire logic        boot_config_select_line_o,
	input wire logic        boot_mirror_bit_o,
	input wire logic        abort_irq_o,
	input wire logic [2:0]  abort_level_o
);
	wire logic [4:0] sel = {sel_mem_o, sel_rom_o, sel_sram_o, sel_lio_o,
		sel_a16_o};
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (!resetn_i);

	a_sel_onehot: assert property ($onehot0(sel))
		else $error("more than one region select");
	a_sel_normal: assert property (|sel |-> $past(ts_i) &&
		$past(transfer_type_code_i) != 2'h3)
		else $error("region select without normal request");
	a_lio_range: assert property (sel_lio_o |->
		$past(addr_i) >= `LBAD_LIO_LO && $past(addr_i) <= `LBAD_LIO_HI)
		else $error("local io select outside its range");
	a_rom_protect: assert property (sel_rom_o |->
		$past(rd_i) || !$past(flash_protect_line_o))
		else $error("rom write selected while protected");
	a_ta_cause: assert property (ta_o |-> $past(ts_i))
		else $error("answer without request");
	a_iack_vector: assert property (ta_o &&
		$past(transfer_type_code_i) == 2'h3 |-> $past(abort_irq_o) &&
		$past(addr_i[3:1]) == abort_level_o &&
		rdata_o == {24'h00_0000, `LBAD_ABORT_VEC})
		else $error("bad abort acknowledge");
	a_gpin_read: assert property (ta_o && $past(rd_i) &&
		$past(addr_i) == `LBAD_A_GPIN |->
		rdata_o[23:16] == $past(general_input_pins_i))
		else $error("input pins read wrong");
	a_half_forced: assert property (boot_config_select_line_o |->
		!flash_half_select_line_o)
		else $error("half select active in flash only mode");
	a_reset_vals: assert property ($past(!resetn_i) |->
		flash_protect_line_o && boot_mirror_bit_o)
		else $error("protect or mirror not set by reset");
	a_irq_inhibit: assert property ($past(vme_present_i) |->
		!abort_irq_o)
		else $error("abort interrupt while inhibited");
endmodule // lbad_top_monitor

bind lbad_top lbad_top_monitor i_mon (.clk_sys_i, .resetn_i, .ts_i,
	.transfer_type_code_i, .addr_i, .rd_i, .general_input_pins_i,
	.vme_present_i, .ta_o, .rdata_o, .sel_mem_o, .sel_rom_o, .sel_sram_o,
	.sel_lio_o, .sel_a16_o, .flash_protect_line_o, .flash_half_select_line_o,
	.boot_config_select_line_o, .boot_mirror_bit_o, .abort_irq_o,
	.abort_level_o);
`default_nettype wire

// ===== verif/tb.sv
// testbench for the local bus decode block
`timescale 1ns/1ns
`default_nettype none
`include "lbad_regs.vh"
module tb;
	logic clk_sys_i = 1'b0, resetn_i = 1'b0, ts_i = 1'b0, rd_s = 1'b0;
	logic [1:0] xtype = 2'h0;
	logic [31:0] addr = 32'h0, wdata = 32'h0, rv;
	logic [7:0] pins = 8'hA5;
	logic vme = 1'b0, sup = 1'b1, abort_sw = 1'b0, rst_sw = 1'b0, x_err = 1'b0;
	logic [3:0] dly = 4'h0;
	logic [4:0] sv;
	logic ev;
	wire ext_ack, ext_err, ta, terr, sm, sr, ss, sl, sa;
	wire prot, half, bcfg, mir, irq, lrst, bfail;
	wire [2:0] lvl;
	wire [31:0] rdata;
	int n_errors = 0, tests_run = 0, cyc = 0, t, i;
	logic [31:0] at [4] = '{32'h0040_0000, 32'hFFE0_0000, 32'hFFF4_7000,
		32'hFFFF_0000};
	logic [4:0] se [4] = '{5'h10, 5'h04, 5'h02, 5'h01};

	always #5 clk_sys_i = ~clk_sys_i;

	lbad_top #(.TO2_CYC(32'd40), .TO3_CYC(32'd80), .WD_BASE_US(32'd2))
	i_lbad_top (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .ts_i(ts_i),
		.transfer_type_code_i(xtype), .addr_i(addr), .rd_i(rd_s),
		.be_i(4'hF), .wdata_i(wdata), .ext_ack_i(ext_ack),
		.ext_err_i(ext_err), .ta_o(ta), .transfer_error_ack_o(terr),
		.rdata_o(rdata), .sel_mem_o(sm), .sel_rom_o(sr), .sel_sram_o(ss),
		.sel_lio_o(sl), .sel_a16_o(sa), .vme_present_i(vme),
		.supply_status_line_i(sup), .general_input_pins_i(pins),
		.abort_sw_i(abort_sw), .reset_sw_i(rst_sw),
		.flash_protect_line_o(prot), .flash_half_select_line_o(half),
		.boot_config_select_line_o(bcfg), .boot_mirror_bit_o(mir),
		.abort_irq_o(irq), .abort_level_o(lvl), .local_reset_o(lrst),
		.board_fail_o(bfail));

	lbad_target_model i_lbad_target_model (.clk_sys_i(clk_sys_i),
		.sel_i(sm | sr | ss | sl | sa), .delay_i(dly), .fail_i(x_err),
		.ack_o(ext_ack), .err_o(ext_err));

	task automatic chk(input string nm, input logic [31:0] s, e);
		tests_run++;
		if (s !== e) begin
			n_errors++;
			$display("[FAIL] %s expected %h seen %h", nm, e, s);
		end
	endtask

	// one request, then wait for answer, error or target acknowledge
	task automatic xfer(input logic [1:0] k, input logic [31:0] a,
		input logic r, input logic [31:0] d);
		int n;
		@(negedge clk_sys_i);
		ts_i = 1'b1;
		xtype = k;
		addr = a;
		rd_s = r;
		wdata = d;
		sv = 5'h0;
		ev = 1'b0;
		@(negedge clk_sys_i);
		ts_i = 1'b0;
		for (n = 0; n < 300; n++) begin // next request after this ends
			sv = sv | {sm, sr, ss, sl, sa};
			if (terr) ev = 1'b1;
			if (ta) rv = rdata;
			if (ta || terr || ext_ack) break;
			@(negedge clk_sys_i);
		end
		if (n == 300) chk("answer", 32'h0, 32'h1);
	endtask

	task automatic wr(input logic [31:0] a, d);
		xfer(2'h0, a, 1'b0, d);
	endtask

	task automatic rdr(input logic [31:0] a);
		xfer(2'h0, a, 1'b1, 32'h0);
	endtask

	task automatic final_report;
		$display("checks %0d mismatches %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	always @(posedge clk_sys_i) begin
		cyc++;
		if (cyc == 20000) begin
			n_errors++;
			final_report;
		end
	end

	initial begin
		repeat (5) @(negedge clk_sys_i);
		resetn_i = 1'b1;
		chk("reset lines", 32'({prot, mir, bcfg}), 32'h6);
		rdr(`LBAD_A_BCTL);
		chk("supply bit", 32'(rv[0]), 32'h1);
		rdr(`LBAD_A_GPIN);
		chk("input pins", 32'(rv[23:16]), 32'hA5);
		wr(`LBAD_A_WDOG, 32'h0100_1000);
		xfer(2'h0, `LBAD_ROM_LO, 1'b0, 32'h0);
		chk("rom write refused", 32'({sv, ev}), 32'h1);
		xfer(2'h0, `LBAD_ROM_LO, 1'b1, 32'h0);
		chk("rom read", 32'({sv, ev}), 32'h10);
		xfer(2'h0, 32'h0, 1'b1, 32'h0);
		chk("mirror read", 32'({sv, ev}), 32'h10);
		for (t = 0; t < 3; t++)
			for (i = 0; i < 4; i++) begin
				dly = 4'(t * 3);
				xfer(2'(t), at[i], 1'b1, 32'h0);
				chk("region", 32'({sv, ev}), 32'({se[i], 1'b0}));
			end
		xfer(2'h3, 32'hFFF4_7000, 1'b1, 32'h0);
		chk("iack no pending", 32'({sv, ev}), 32'h1);
		rdr(`LBAD_A_BERR);
		chk("iack timeout bits", 32'(rv[11:8]), 32'hB);
		wr(`LBAD_A_BERR, 32'h0000_0F00);
		xfer(2'h0, 32'hFFC0_0000, 1'b1, 32'h0);
		chk("undecoded", 32'({sv, ev}), 32'h1);
		rdr(`LBAD_A_BERR);
		chk("timeout bits", 32'(rv[11:8]), 32'h3);
		wr(`LBAD_A_BERR, 32'h0000_0F00);
		x_err = 1'b1;
		xfer(2'h0, 32'hFFF4_7000, 1'b1, 32'h0);
		x_err = 1'b0;
		chk("ext error", 32'({sv, ev}), 32'h5);
		rdr(`LBAD_A_BERR);
		chk("ext error bits", 32'(rv[11:8]), 32'h5);
		wr(`LBAD_A_BCTL, 32'h0000_0004);
		@(negedge clk_sys_i);
		chk("half select", 32'({prot, half, bcfg}), 32'h2);
		xfer(2'h0, `LBAD_ROM_LO, 1'b0, 32'h0);
		chk("rom write open", 32'({sv, ev}), 32'h10);
		wr(`LBAD_A_BCTL, 32'h0000_000C);
		@(negedge clk_sys_i);
		chk("flash only", 32'({prot, half, bcfg}), 32'h1);
		wr(`LBAD_A_ROMCTL, 32'h0);
		xfer(2'h0, 32'h0, 1'b1, 32'h0);
		chk("mirror off", 32'({mir, sv, ev}), 32'h20);
		wr(`LBAD_A_ABORT, 32'h0000_0015);
		abort_sw = 1'b1;
		repeat (3) @(negedge clk_sys_i);
		chk("abort irq", 32'({irq, lvl}), 32'hD);
		rdr(`LBAD_A_ABORT);
		chk("abort ctl", 32'(rv[6:0]), 32'h75);
		xfer(2'h3, 32'h0000_000A, 1'b1, 32'h0);
		chk("abort vector", rv, 32'h40);
		vme = 1'b1;
		repeat (2) @(negedge clk_sys_i);
		chk("irq inhibited", 32'(irq), 32'h0);
		vme = 1'b0;
		@(negedge clk_sys_i);
		chk("irq restored", 32'(irq), 32'h1);
		wr(`LBAD_A_ABORT, 32'h0000_001D);
		@(negedge clk_sys_i);
		chk("abort cleared", 32'(irq), 32'h0);
		abort_sw = 1'b0;
		wr(`LBAD_A_PRESC, 32'h1234_0000);
		rdr(`LBAD_A_PRESC2);
		chk("prescaler alias", 32'(rv[31:16]), 32'h1234);
		rst_sw = 1'b1;
		repeat (3) @(negedge clk_sys_i);
		chk("reset switch", 32'(lrst), 32'h1);
		rdr(`LBAD_A_WDOG);
		chk("timer fields", 32'({rv[28], rv[13:12]}), 32'h5);
		rst_sw = 1'b0;
		wr(`LBAD_A_WDOG, 32'h0141_1000);
		chk("fail idle", 32'(bfail), 32'h0);
		repeat (250) @(negedge clk_sys_i);
		chk("board fail", 32'(bfail), 32'h1);
		rdr(`LBAD_A_WDOG);
		chk("watchdog expired", 32'(rv[20]), 32'h1);
		final_report;
	end
endmodule // tb
`default_nettype wire
